// File: hw/hs_homing_seq.sv
// Purpose: homing sequencer ordering direction and speed of an axis
// Assumes: START_I and METHOD_I come from logic on CLK_I
// Notes:   speed values and motion profiling live elsewhere
//
// Operation
// - method ten limit hit: reverse, then index
// - ten/eleven switch active: positive slow, index
// - eleven no limit: negative fast, slow, index
// - eleven limit: reverse positive fast, then index
// - twelve no limit: pos slow, neg slow, index
// - twelve limit: reverse, pos slow, neg slow
// - twelve active: pos slow, neg slow, index
// - thirteen no limit: neg slow, pos slow
// - thirteen limit: reverse, pos slow throughout
// - thirteen active: positive slow, next rise index
// - fourteen no limit: negative all the way
// - fourteen limit: reverse, then negative slow
// - fourteen active: negative slow, index after fall
// - seventeen homes on negative limit falling edge
// - eighteen homes on positive limit falling edge
// - nineteen homes on home switch falling edge
// - twenty inactive: positive slow, stop on rise
`timescale 1ns/1ps
module hs_homing_seq (
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  input  wire logic               START_I,
  input  wire hs_pkg::hs_method_t METHOD_I,
  input  wire logic               HOME_SW_I,
  input  wire logic               NEG_LIM_I,
  input  wire logic               POS_LIM_I,
  input  wire logic               INDEX_I,
  output logic                    MOVE_O,
  output logic                    DIR_POS_O,
  output logic                    HIGH_SPD_O,
  output logic                    BUSY_O,
  output logic                    DONE_O,
  output logic                    ERR_O
);
  import hs_pkg::*;

  hs_edges_t  home_e;
  hs_edges_t  nlim_e;
  hs_edges_t  plim_e;
  hs_edges_t  idx_e;
  hs_edges_t  ref_e;
  hs_edges_t  start_ref_e;
  hs_phase_t  phase_r;
  hs_method_t meth_r;
  hs_prof_t   prof;
  hs_prof_t   start_prof;
  logic       dir_pos_r;
  logic       fast_r;
  logic       move_r;
  logic       done_r;
  logic       err_r;
  logic       travel_lim;

  // pins enter through two flops before any decision
  hs_sync_edge u_home (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .pin_i   (HOME_SW_I),
    .edges_o (home_e)
  );

  hs_sync_edge u_nlim (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .pin_i   (NEG_LIM_I),
    .edges_o (nlim_e)
  );

  hs_sync_edge u_plim (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .pin_i   (POS_LIM_I),
    .edges_o (plim_e)
  );

  hs_sync_edge u_idx (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .pin_i   (INDEX_I),
    .edges_o (idx_e)
  );

  // direction table; 1 means positive
  function automatic hs_prof_t hs_profile(input hs_method_t m);
    hs_prof_t p;
    p = '0;
    case (m)
      HS_M10: begin
        p.ok = 1'b1; p.fast_pos = 1'b1; p.slowa_pos = 1'b1;
        p.slowa_lim_pos = 1'b1; p.act_pos = 1'b1;
        p.lim_rev_en = 1'b1; p.idx_end = 1'b1;
      end
      HS_M11: begin
        p.ok = 1'b1; p.fast_pos = 1'b0; p.slowa_pos = 1'b0;
        p.slowa_lim_pos = 1'b0;
        p.act_pos = 1'b1;
        p.lim_rev_en = 1'b1; p.idx_end = 1'b1;
      end
      HS_M12: begin
        p.ok = 1'b1; p.fast_pos = 1'b0; p.slowa_pos = 1'b1;
        p.slowa_lim_pos = 1'b1; p.slowb_pos = 1'b0;
        p.act_pos = 1'b1;
        p.lim_rev_en = 1'b1; p.two_edge = 1'b1; p.idx_end = 1'b1;
      end
      HS_M13: begin
        p.ok = 1'b1; p.fast_pos = 1'b0; p.slowa_pos = 1'b0;
        p.slowa_lim_pos = 1'b1; p.slowb_pos = 1'b1;
        p.act_pos = 1'b1;
        p.lim_rev_en = 1'b1; p.two_edge = 1'b1; p.idx_end = 1'b1;
      end
      HS_M14: begin
        p.ok = 1'b1; p.fast_pos = 1'b0; p.slowa_pos = 1'b0;
        p.slowa_lim_pos = 1'b0;
        p.act_pos = 1'b0;
        p.lim_rev_en = 1'b1; p.idx_end = 1'b1;
      end
      HS_M17: begin
        p.ok = 1'b1; p.fast_pos = 1'b0; p.slowa_pos = 1'b1;
        p.slowa_lim_pos = 1'b1; p.act_pos = 1'b1;
      end
      HS_M18: begin
        p.ok = 1'b1; p.fast_pos = 1'b1; p.slowa_pos = 1'b0;
        p.slowa_lim_pos = 1'b0; p.act_pos = 1'b0;
      end
      HS_M19: begin
        p.ok = 1'b1; p.fast_pos = 1'b1; p.slowa_pos = 1'b0;
        p.slowa_lim_pos = 1'b0; p.act_pos = 1'b0;
      end
      HS_M20: begin
        p.ok = 1'b1; p.fast_pos = 1'b0; p.slowb_pos = 1'b1;
        p.act_pos = 1'b0;
      end
      default: begin
        p.ok = 1'b0;
      end
    endcase
    return p;
  endfunction : hs_profile

  // reference switch: limit switch for 17/18, home switch otherwise
  function automatic hs_edges_t hs_ref(input hs_method_t m,
                                       input hs_edges_t  h,
                                       input hs_edges_t  n,
                                       input hs_edges_t  p);
    hs_edges_t r;
    case (m)
      HS_M17:  r = n;
      HS_M18:  r = p;
      default: r = h;
    endcase
    return r;
  endfunction : hs_ref

  always_comb begin
    prof        = hs_profile(meth_r);
    start_prof  = hs_profile(METHOD_I);
    ref_e       = hs_ref(meth_r, home_e, nlim_e, plim_e);
    start_ref_e = hs_ref(METHOD_I, home_e, nlim_e, plim_e);
    // limit in the direction of the fast search
    travel_lim  = prof.fast_pos ? plim_e.lvl : nlim_e.lvl;
  end

  // method latched at start so a changing selector cannot disturb a run
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      meth_r <= '0;
    end else if (START_I && !move_r) begin
      meth_r <= METHOD_I;
    end
  end

  // sequencing of phase, direction and speed
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase_r   <= PH_IDLE;
      dir_pos_r <= RST_DIR_POS;
      fast_r    <= RST_FAST;
      move_r    <= RST_MOVE;
    end else begin
      case (phase_r)
        PH_IDLE, PH_DONE: begin
          if (START_I && start_prof.ok) begin
            move_r    <= 1'b1;
            // branch chosen from switch level sampled now
            if (start_ref_e.lvl) begin
              if (METHOD_I == HS_M20) begin
                phase_r   <= PH_FAST;
                dir_pos_r <= 1'b0;
                fast_r    <= 1'b1;
              end else begin
                phase_r   <= PH_SLOW_A;
                dir_pos_r <= start_prof.act_pos;
                fast_r    <= 1'b0;
              end
            end else if (METHOD_I == HS_M20) begin
              phase_r   <= PH_SLOW_B;
              dir_pos_r <= start_prof.slowb_pos;
              fast_r    <= 1'b0;
            end else begin
              phase_r   <= PH_FAST;
              dir_pos_r <= start_prof.fast_pos;
              fast_r    <= 1'b1;
            end
          end
        end
        PH_FAST: begin
          if (meth_r == HS_M20) begin
            if (ref_e.fall) begin
              phase_r   <= PH_SLOW_B;
              dir_pos_r <= prof.slowb_pos;
              fast_r    <= 1'b0;
            end
          end else if (prof.lim_rev_en && travel_lim) begin
            // limit wins over a same-cycle edge: axis must not go on
            phase_r   <= PH_REV;
            dir_pos_r <= ~dir_pos_r;
          end else if (ref_e.rise) begin
            phase_r   <= PH_SLOW_A;
            dir_pos_r <= prof.slowa_pos;
            fast_r    <= 1'b0;
          end
        end
        PH_REV: begin
          if (ref_e.rise) begin
            phase_r   <= PH_SLOW_A;
            dir_pos_r <= prof.slowa_lim_pos;
            fast_r    <= 1'b0;
          end
        end
        PH_SLOW_A: begin
          if (ref_e.fall) begin
            if (prof.two_edge) begin
              phase_r   <= PH_SLOW_B;
              dir_pos_r <= prof.slowb_pos;
            end else if (prof.idx_end) begin
              phase_r <= PH_INDEX;
            end else begin
              phase_r <= PH_DONE;
              move_r  <= 1'b0;
            end
          end
        end
        PH_SLOW_B: begin
          if (ref_e.rise) begin
            if (prof.idx_end) begin
              phase_r <= PH_INDEX;
            end else begin
              phase_r <= PH_DONE;
              move_r  <= 1'b0;
            end
          end
        end
        PH_INDEX: begin
          // only index pulses after entering this phase count
          if (idx_e.rise) begin
            phase_r <= PH_DONE;
            move_r  <= 1'b0;
          end
        end
        default: begin
          phase_r <= PH_IDLE;
          move_r  <= 1'b0;
        end
      endcase
    end
  end

  // done is held until the next start while not moving, even one with a bad method
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      done_r <= RST_DONE;
    end else if (START_I && !move_r) begin
      done_r <= 1'b0;
    end else if (move_r &&
                 ((phase_r == PH_INDEX && idx_e.rise) ||
                  (phase_r == PH_SLOW_A && ref_e.fall &&
                   !prof.two_edge && !prof.idx_end) ||
                  (phase_r == PH_SLOW_B && ref_e.rise &&
                   !prof.idx_end))) begin
      done_r <= 1'b1;
    end
  end

  // unsupported method refused; flag kept until a good start
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      err_r <= RST_ERR;
    end else if (START_I && !move_r) begin
      err_r <= ~start_prof.ok;
    end
  end

  always_comb begin
    MOVE_O     = move_r;
    DIR_POS_O  = dir_pos_r;
    HIGH_SPD_O = fast_r;
    BUSY_O     = move_r;
    DONE_O     = done_r;
    ERR_O      = err_r;
  end

endmodule : hs_homing_seq

// File: hw/hs_pkg.sv
// Purpose: shared types and constants of the homing sequencer
// Assumes: one 40 MHz clock, method code given as an 8-bit number
// Notes:   phases are shared by all supported methods
package hs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;

  typedef logic [7:0] hs_method_t;

  localparam hs_method_t HS_M10 = 8'h0A;
  localparam hs_method_t HS_M11 = 8'h0B;
  localparam hs_method_t HS_M12 = 8'h0C;
  localparam hs_method_t HS_M13 = 8'h0D;
  localparam hs_method_t HS_M14 = 8'h0E;
  localparam hs_method_t HS_M17 = 8'h11;
  localparam hs_method_t HS_M18 = 8'h12;
  localparam hs_method_t HS_M19 = 8'h13;
  localparam hs_method_t HS_M20 = 8'h14;

  localparam logic       RST_DIR_POS = 1'b0;
  localparam logic       RST_FAST    = 1'b0;
  localparam logic       RST_MOVE    = 1'b0;
  localparam logic       RST_DONE    = 1'b0;
  localparam logic       RST_ERR     = 1'b0;
  localparam logic [2:0] RST_SYNC    = 3'h0;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_FAST   = 3'b001,
    PH_REV    = 3'b010,
    PH_SLOW_A = 3'b011,
    PH_SLOW_B = 3'b100,
    PH_INDEX  = 3'b101,
    PH_DONE   = 3'b110
  } hs_phase_t;

  // synchronised level plus single-cycle edge pulses
  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } hs_edges_t;

  // per-method direction and step profile
  typedef struct packed {
    logic ok;
    logic fast_pos;
    logic slowa_pos;
    logic slowa_lim_pos;
    logic slowb_pos;
    logic act_pos;
    logic lim_rev_en;
    logic two_edge;
    logic idx_end;
  } hs_prof_t;

endpackage : hs_pkg

// File: hw/hs_sync_edge.sv
// Purpose: two-flop synchroniser with edge pulses for one pin
// Assumes: pin is asynchronous to CLK_I
// Notes:   first flop feeds only the second flop
`timescale 1ns/1ps
module hs_sync_edge (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          pin_i,
  output hs_pkg::hs_edges_t  edges_o
);
  import hs_pkg::*;

  logic [2:0] sh_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_r <= RST_SYNC;
    end else begin
      sh_r <= {sh_r[1:0], pin_i};
    end
  end

  // edges judged from flops two and three only
  always_comb begin
    edges_o.lvl  = sh_r[1];
    edges_o.rise = sh_r[1] & ~sh_r[2];
    edges_o.fall = ~sh_r[1] & sh_r[2];
  end

endmodule : hs_sync_edge

// File: verif/hs_axis_model.sv
// Purpose: switch and index pin model of the axis
// Assumes: bench sets pin levels through set_pins only
// Notes:   push-pull levels, no contact bounce modelled
`timescale 1ns/1ps
module hs_axis_model (
  input  wire logic clk_i,
  output logic      home_o,
  output logic      nlim_o,
  output logic      plim_o,
  output logic      idx_o
);
  logic [3:0] pins_r = 4'h0;
  assign {home_o, nlim_o, plim_o, idx_o} = pins_r;
  // change right after an edge so no sample ever races the update
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_i);
    pins_r <= v;
  endtask : set_pins
endmodule : hs_axis_model

// File: verif/hs_seq_properties.sv
// Purpose: port checks of the homing sequencer
// Assumes: one clock, asynchronous active-high reset
// Notes:   pin reactions expected exactly 3 cycles after the change
`timescale 1ns/1ps
module hs_seq_props (
  input wire logic               CLK_I,
  input wire logic               RST_I,
  input wire logic               START_I,
  input wire hs_pkg::hs_method_t METHOD_I,
  input wire logic               HOME_SW_I,
  input wire logic               NEG_LIM_I,
  input wire logic               POS_LIM_I,
  input wire logic               INDEX_I,
  input wire logic               MOVE_O,
  input wire logic               DIR_POS_O,
  input wire logic               HIGH_SPD_O,
  input wire logic               BUSY_O,
  input wire logic               DONE_O,
  input wire logic               ERR_O
);
  import hs_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire logic [3:0] pins = {HOME_SW_I, NEG_LIM_I, POS_LIM_I, INDEX_I};
  wire logic ok_m = METHOD_I inside {HS_M10, HS_M11, HS_M12, HS_M13,
                                     HS_M14, HS_M17, HS_M18, HS_M19, HS_M20};
  sequence s_take;
    START_I && !MOVE_O;
  endsequence
  // two sync flops plus sequencer register: change shows 3 samples back
  sequence s_pin_moved;
    $past(pins, 3) != $past(pins, 4);
  endsequence
  AST_TAKE_RUN: assert property (
    s_take ##0 ok_m |=> MOVE_O && !DONE_O)
    else $error("valid start did not launch motion");
  AST_TAKE_BAD: assert property (s_take ##0 !ok_m |=> ERR_O && !MOVE_O)
    else $error("bad method not refused");
  AST_NO_SELF_START: assert property (
    $rose(MOVE_O) |-> $past(START_I))
    else $error("motion began without a start");
  AST_BUSY: assert property (BUSY_O == MOVE_O)
    else $error("busy differs from move");
  AST_DONE_HOLD: assert property (DONE_O && !START_I |=> DONE_O)
    else $error("done dropped without a start");
  AST_STOP_DONE: assert property ($fell(MOVE_O) |-> DONE_O)
    else $error("stop without done");
  AST_STOP_LAG: assert property ($fell(MOVE_O) |-> s_pin_moved)
    else $error("stop not three cycles after a pin edge");
  // first cycle of a run may turn on a limit already pressed
  AST_TURN_LAG: assert property (
    MOVE_O && $past(MOVE_O) && $past(MOVE_O, 2) &&
    ($changed(DIR_POS_O) || $changed(HIGH_SPD_O)) |-> s_pin_moved)
    else $error("direction or speed changed off a pin edge");
endmodule : hs_seq_props

bind hs_homing_seq hs_seq_props u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .START_I(START_I), .METHOD_I(METHOD_I),
  .HOME_SW_I(HOME_SW_I), .NEG_LIM_I(NEG_LIM_I), .POS_LIM_I(POS_LIM_I),
  .INDEX_I(INDEX_I), .MOVE_O(MOVE_O), .DIR_POS_O(DIR_POS_O),
  .HIGH_SPD_O(HIGH_SPD_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .ERR_O(ERR_O));

// File: verif/tb_top.sv
// Purpose: directed bench for the homing sequencer
// Assumes: result is {move, dir while moving, speed, done, error}
//          and busy must always follow move
// Notes:   fixed waits follow the stated 3-cycle pin lag
`timescale 1ns/1ps
module tb_top;
  import hs_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       start = 1'b0;
  hs_method_t method = 8'h00;
  logic       home, nlim, plim, idx, mv, dir, spd, busy, done, err;
  int         miscompares = 0;
  int         checks = 0;
  always #12.5 clk = ~clk;
  hs_axis_model u_axis (.clk_i(clk), .home_o(home), .nlim_o(nlim),
    .plim_o(plim), .idx_o(idx));
  hs_homing_seq u_dut (.CLK_I(clk), .RST_I(rst), .START_I(start),
    .METHOD_I(method), .HOME_SW_I(home), .NEG_LIM_I(nlim),
    .POS_LIM_I(plim), .INDEX_I(idx), .MOVE_O(mv), .DIR_POS_O(dir),
    .HIGH_SPD_O(spd), .BUSY_O(busy), .DONE_O(done), .ERR_O(err));
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [4:0] exp);
    logic [5:0] got;
    got = {busy, mv, dir & mv, spd, done, err};
    checks++;
    if (got !== {exp[4], exp}) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got,
               {exp[4], exp});
    end
  endtask : chk
  // pins settle through the synchroniser before the start is given
  task automatic go(input hs_method_t m, input logic [3:0] p,
                    input logic [4:0] exp);
    u_axis.set_pins(p);
    repeat (5) @(posedge clk);
    start <= 1'b1;
    method <= m;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(exp);
  endtask : go
  task automatic ev(input logic [3:0] p, input logic [4:0] exp);
    u_axis.set_pins(p);
    repeat (5) @(posedge clk);
    #1 chk(exp);
  endtask : ev
  // start given while moving must be ignored
  task automatic again(input hs_method_t m, input logic [4:0] exp);
    @(posedge clk);
    start <= 1'b1;
    method <= m;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(exp);
  endtask : again
  task automatic sc_m11_plain;
    go(HS_M11, 4'h0, 5'h14);
    ev(4'h8, 5'h10);
    ev(4'h9, 5'h10);
    ev(4'h8, 5'h10);
    ev(4'h0, 5'h10);
    ev(4'h1, 5'h02);
  endtask : sc_m11_plain
  task automatic sc_m10_limit;
    go(HS_M10, 4'h0, 5'h1C);
    ev(4'h2, 5'h14);
    ev(4'h0, 5'h14);
    ev(4'h8, 5'h18);
    ev(4'h0, 5'h18);
    ev(4'h1, 5'h02);
  endtask : sc_m10_limit
  task automatic sc_m11_limit;
    go(HS_M11, 4'h0, 5'h14);
    ev(4'h4, 5'h1C);
    ev(4'h8, 5'h10);
    ev(4'h0, 5'h10);
    ev(4'h1, 5'h02);
  endtask : sc_m11_limit
  task automatic sc_m12_plain;
    go(HS_M12, 4'h0, 5'h14);
    ev(4'h8, 5'h18);
    ev(4'h0, 5'h10);
    ev(4'h8, 5'h10);
    ev(4'h9, 5'h02);
  endtask : sc_m12_plain
  task automatic sc_m13_limit;
    go(HS_M13, 4'h0, 5'h14);
    ev(4'h4, 5'h1C);
    ev(4'h8, 5'h18);
    ev(4'h0, 5'h18);
    ev(4'h8, 5'h18);
    ev(4'h9, 5'h02);
  endtask : sc_m13_limit
  task automatic sc_active;
    go(HS_M14, 4'h8, 5'h10);
    ev(4'h0, 5'h10);
    ev(4'h1, 5'h02);
    go(HS_M10, 4'h8, 5'h18);
    ev(4'h0, 5'h18);
    ev(4'h1, 5'h02);
  endtask : sc_active
  task automatic sc_edge_homes;
    go(HS_M17, 4'h0, 5'h14);
    ev(4'h4, 5'h18);
    ev(4'h0, 5'h02);
    go(HS_M18, 4'h0, 5'h1C);
    ev(4'h2, 5'h10);
    ev(4'h0, 5'h02);
    go(HS_M19, 4'h0, 5'h1C);
    ev(4'h8, 5'h10);
    ev(4'h0, 5'h02);
    go(HS_M20, 4'h0, 5'h18);
    ev(4'h8, 5'h02);
  endtask : sc_edge_homes
  task automatic sc_m12_more;
    go(HS_M12, 4'h0, 5'h14);
    ev(4'h4, 5'h1C);
    ev(4'h8, 5'h18);
    ev(4'h0, 5'h10);
    ev(4'h8, 5'h10);
    ev(4'h9, 5'h02);
    go(HS_M12, 4'h8, 5'h18);
    ev(4'h0, 5'h10);
    ev(4'h8, 5'h10);
    ev(4'h9, 5'h02);
  endtask : sc_m12_more
  task automatic sc_m13_more;
    go(HS_M13, 4'h0, 5'h14);
    ev(4'h8, 5'h10);
    ev(4'h0, 5'h18);
    ev(4'h8, 5'h18);
    ev(4'h9, 5'h02);
    go(HS_M13, 4'h8, 5'h18);
    ev(4'h0, 5'h18);
    ev(4'h8, 5'h18);
    ev(4'h9, 5'h02);
  endtask : sc_m13_more
  task automatic sc_m14_more;
    go(HS_M14, 4'h0, 5'h14);
    again(HS_M18, 5'h14);
    ev(4'h8, 5'h10);
    ev(4'h0, 5'h10);
    ev(4'h1, 5'h02);
    go(HS_M14, 4'h0, 5'h14);
    ev(4'h4, 5'h1C);
    ev(4'h8, 5'h10);
    ev(4'h0, 5'h10);
    ev(4'h1, 5'h02);
    go(HS_M11, 4'h8, 5'h18);
    ev(4'h0, 5'h18);
    ev(4'h1, 5'h02);
  endtask : sc_m14_more
  task automatic sc_active_more;
    go(HS_M17, 4'h4, 5'h18);
    ev(4'h0, 5'h02);
    go(HS_M18, 4'h2, 5'h10);
    ev(4'h0, 5'h02);
    go(HS_M19, 4'h8, 5'h10);
    ev(4'h0, 5'h02);
    go(HS_M20, 4'h8, 5'h14);
    ev(4'h0, 5'h18);
    ev(4'h8, 5'h02);
  endtask : sc_active_more
  task automatic sc_bad;
    go(8'h05, 4'h0, 5'h01);
  endtask : sc_bad
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sc_m11_plain;
    sc_m10_limit;
    sc_m11_limit;
    sc_m12_plain;
    sc_m13_limit;
    sc_active;
    sc_edge_homes;
    sc_m12_more;
    sc_m13_more;
    sc_m14_more;
    sc_active_more;
    sc_bad;
    report_and_stop;
  end
  // a hang shows up as a missed verdict, so cap the whole run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule : tb_top
